/* File: imd_decode.v */
// Purpose: Forwarding decision for ISA DMA and master memory cycles and
//          PCI interrupt trigger and board interrupt steering.
// Assumes: Config writes and reads come from the bridge's config port on
//          the same clock; ISA address and request are synchronous to it.
// Notes:   Hole and 512K registers are kept here so the decode is whole.
//          Every output is registered, so the decision for a cycle
//          presented at one edge shows after that edge and lasts one
//          clock; the far side must hold its cycle for that long.
//          Interrupt pins are asynchronous and pay two sync stages.
`timescale 1ns/10ps
`default_nettype none
`include "imd_defines.vh"
module imd_decode (
    input  wire        CLOCK_IN,
    input  wire        SYS_RST_IN,
    input  wire        CFG_WR_IN,
    input  wire [7:0]  CFG_ADDR_IN,
    input  wire [7:0]  CFG_WDATA_IN,
    output reg  [7:0]  CFG_RDATA_OUT,
    input  wire        ISA_REQ_IN,
    input  wire [23:0] ISA_ADDR_IN,
    output reg         PCI_FWD_OUT,
    output reg         ISA_LOCAL_OUT,
    input  wire [3:0]  PCI_INT_LINES_IN,
    output reg  [3:0]  PCI_INT_COND_OUT,
    output reg  [3:0]  PCI_INT_EDGE_OUT,
    input  wire        BOARD_INT_INPUT_ZERO_IN,
    input  wire        BOARD_INT_INPUT_ONE_IN,
    output reg  [15:0] ISA_IRQ_OUT
);
    reg  [15:0] fwd_ctrl_q;
    reg  [7:0]  trig_sel_q;
    reg  [7:0]  route_q;
    reg  [7:0]  hole_bot_q;
    reg  [7:0]  hole_top_q;
    reg         half_mb_q;
    reg  [3:0]  int_s1_q;
    reg  [3:0]  int_s2_q;
    reg  [1:0]  brd_s1_q;
    reg  [1:0]  brd_s2_q;
    reg  [24:0] top_lim;
    reg         in_range;
    reg         fwd_d;
    wire        hole_hit;
    wire [2:0]  seg_idx;
    wire [7:0]  hole_seg;
    wire [31:0] lane_irq;
    genvar      g;

    // ------------------------------------------------------------------
    // Register map, byte offsets on the config port.
    // ------------------------------------------------------------------
    // 4Ch  hole bottom, address bits 23-16 of the first byte inside it.
    // 4Dh  hole top, address bits 23-16 of the first byte past it.
    // 4Eh  segment enables for C0000h-DFFFFh, one bit per 16 KB.
    // 4Fh  top-of-memory code in 7-4, range enables in 3-0.
    // 48h  bit 0 adds 512 KB to the top of memory; other bits read 0.
    // 54h  trigger select, 3-0 for lines A to D; 7-4 read 0.
    // 55h  routing, 3-0 for board input zero and 7-4 for input one.
    // 56h  fixed byte; writes are dropped and reads return 04h.
    // Any other offset reads 0 and ignores writes.

    // ------------------------------------------------------------------
    // Configuration registers.
    // ------------------------------------------------------------------
    // Reserved byte has no storage at all, so writes simply vanish.
    // The two control bytes are written on their own, so software may
    // move the segment enables without touching the top of memory.
    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            fwd_ctrl_q <= `IMD_FWD_RESET;
            trig_sel_q <= `IMD_TRIG_RESET;
            route_q    <= `IMD_ROUTE_RESET;
            hole_bot_q <= `IMD_HOLE_RESET;
            hole_top_q <= `IMD_HOLE_RESET;
            half_mb_q  <= `IMD_HALF_RESET;
        end else if (CFG_WR_IN) begin
            case (CFG_ADDR_IN)
                `IMD_OFS_FWD_LO:   fwd_ctrl_q[7:0]  <= CFG_WDATA_IN;
                `IMD_OFS_FWD_HI:   fwd_ctrl_q[15:8] <= CFG_WDATA_IN;
                `IMD_OFS_TRIG:     trig_sel_q <= {`IMD_TRIG_PAD,
                                      CFG_WDATA_IN[`IMD_TRIG_MSB:0]};
                `IMD_OFS_ROUTE:    route_q    <= CFG_WDATA_IN;
                `IMD_OFS_HOLE_BOT: hole_bot_q <= CFG_WDATA_IN;
                `IMD_OFS_HOLE_TOP: hole_top_q <= CFG_WDATA_IN;
                `IMD_OFS_MISC3:    half_mb_q  <= CFG_WDATA_IN[`IMD_HALF_BIT];
                default: ;
            endcase
        end
    end

    // Read data is registered, so it appears one cycle after the address.
    // Unmapped offsets read zero so a stray probe sees nothing live.
    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            CFG_RDATA_OUT <= `IMD_RDATA_NONE;
        end else begin
            case (CFG_ADDR_IN)
                `IMD_OFS_FWD_LO:   CFG_RDATA_OUT <= fwd_ctrl_q[7:0];
                `IMD_OFS_FWD_HI:   CFG_RDATA_OUT <= fwd_ctrl_q[15:8];
                `IMD_OFS_TRIG:     CFG_RDATA_OUT <= trig_sel_q;
                `IMD_OFS_ROUTE:    CFG_RDATA_OUT <= route_q;
                `IMD_OFS_RSVD:     CFG_RDATA_OUT <= `IMD_RSVD_VALUE;
                `IMD_OFS_HOLE_BOT: CFG_RDATA_OUT <= hole_bot_q;
                `IMD_OFS_HOLE_TOP: CFG_RDATA_OUT <= hole_top_q;
                `IMD_OFS_MISC3:    CFG_RDATA_OUT <= {7'h00, half_mb_q};
                default:           CFG_RDATA_OUT <= `IMD_RDATA_NONE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Memory forwarding decode.
    // ------------------------------------------------------------------
    // Limit is (code+1) MB, plus 512 KB when the option is set.
    // One spare top bit keeps the 16 MB case from wrapping to zero.
    always @* begin
        top_lim = {1'b0, fwd_ctrl_q[`IMD_TOP_MSB:`IMD_TOP_LSB], `IMD_MB_PAD} +
                  `IMD_ONE_MB;
        if (half_mb_q) begin
            top_lim = top_lim + `IMD_HALF_MB;
        end
    end

    assign seg_idx  = ISA_ADDR_IN[`IMD_SEG_MSB:`IMD_SEG_LSB];
    assign hole_seg = ISA_ADDR_IN[`IMD_MB_MSB:`IMD_HOLE_LSB];
    // An empty or inverted hole is ignored rather than matching nothing.
    // The hole works in 64 KB steps, the grain of its two registers.
    assign hole_hit = (hole_top_q > hole_bot_q) &&
                      (hole_seg >= hole_bot_q) &&
                      (hole_seg < hole_top_q);

    // Low megabyte uses the range enables; above it only the limit and the hole count.
    // F0000h-FFFFFh has no enable of its own and stays on ISA, and the
    // low 512 KB is the default arm of the case.
    // Limit, hole and range are all vetoes: any one of them keeps the
    // cycle off PCI, so their order does not matter.
    always @* begin
        in_range = 1'b1;
        if (ISA_ADDR_IN[`IMD_MB_MSB:`IMD_MB_LSB] == `IMD_LOW_MB) begin
            case (ISA_ADDR_IN[`IMD_BLK_MSB:`IMD_BLK_LSB])
                `IMD_BLK_BASE: in_range = fwd_ctrl_q[`IMD_FWD_BASE_BIT];
                `IMD_BLK_VGA:  in_range = fwd_ctrl_q[`IMD_FWD_VGA_BIT];
                `IMD_BLK_SEG:  in_range = fwd_ctrl_q[seg_idx];
                `IMD_BLK_EXT:  in_range = ~ISA_ADDR_IN[`IMD_SEG_MSB] &
                                          fwd_ctrl_q[`IMD_FWD_EXT_BIT];
                default:       in_range = fwd_ctrl_q[`IMD_FWD_LOW_BIT];
            endcase
        end
        fwd_d = ISA_REQ_IN && in_range && !hole_hit &&
                ({1'b0, ISA_ADDR_IN} < top_lim);
    end

    // Cycles not claimed on PCI stay on ISA.
    // Both flags come from one decision, so they can never both be high,
    // and an idle cycle leaves both low.
    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            PCI_FWD_OUT   <= 1'b0;
            ISA_LOCAL_OUT <= 1'b0;
        end else begin
            PCI_FWD_OUT   <= fwd_d;
            ISA_LOCAL_OUT <= ISA_REQ_IN & ~fwd_d;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt conditioning and steering.
    // ------------------------------------------------------------------
    // Pins pass two flops before any logic sees them.
    // The first stage may go metastable; only the second feeds logic.
    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            int_s1_q <= 4'h0;
            int_s2_q <= 4'h0;
            brd_s1_q <= 2'b00;
            brd_s2_q <= 2'b00;
        end else begin
            int_s1_q <= PCI_INT_LINES_IN;
            int_s2_q <= int_s1_q;
            brd_s1_q <= {BOARD_INT_INPUT_ONE_IN, BOARD_INT_INPUT_ZERO_IN};
            brd_s2_q <= brd_s1_q;
        end
    end

    // Bit 3 is line A down to bit 0 for line D, matching the port order.
    // Edge mode only inverts the line here; catching the edge itself is
    // left to the interrupt controller downstream.
    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            PCI_INT_COND_OUT <= 4'h0;
            PCI_INT_EDGE_OUT <= 4'h0;
        end else begin
            PCI_INT_COND_OUT <= int_s2_q ^ trig_sel_q[`IMD_TRIG_MSB:0];
            PCI_INT_EDGE_OUT <= trig_sel_q[`IMD_TRIG_MSB:0];
        end
    end

    // ------------------------------------------------------------------
    // Board interrupt steering.
    // ------------------------------------------------------------------
    // One lane per board input turns its routing code into a one-hot
    // IRQ vector; code zero leaves the lane dark.
    generate
        for (g = 0; g < `IMD_BOARD_INPUTS; g = g + 1) begin : gen_route
            assign lane_irq[g*`IMD_IRQ_W +: `IMD_IRQ_W] =
                (route_q[g*`IMD_ROUTE_W +: `IMD_ROUTE_W] != `IMD_IRQ_OFF &&
                 brd_s2_q[g]) ?
                (`IMD_IRQ_ONE << route_q[g*`IMD_ROUTE_W +: `IMD_ROUTE_W]) :
                `IMD_IRQ_NONE;
        end
    endgenerate

    // Reserved codes are not filtered; software must avoid them.
    // Two lanes naming the same IRQ simply merge onto that line.
    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            ISA_IRQ_OUT <= `IMD_IRQ_NONE;
        end else begin
            ISA_IRQ_OUT <= lane_irq[15:0] | lane_irq[31:16];
        end
    end
endmodule
`default_nettype wire

/* File: imd_defines.vh */
// Purpose: Constants for the ISA master memory decode and interrupt steering.
// Assumes: Byte-wide configuration access at byte offsets.
// Notes:   Offsets, reset values and field positions are listed below.
`ifndef IMD_DEFINES_VH
`define IMD_DEFINES_VH
`define IMD_OFS_FWD_LO   8'h4E
`define IMD_OFS_FWD_HI   8'h4F
`define IMD_OFS_TRIG     8'h54
`define IMD_OFS_ROUTE    8'h55
`define IMD_OFS_RSVD     8'h56
`define IMD_OFS_HOLE_BOT 8'h4C
`define IMD_OFS_HOLE_TOP 8'h4D
`define IMD_OFS_MISC3    8'h48
`define IMD_FWD_RESET    16'h0300
`define IMD_RSVD_VALUE   8'h04
`define IMD_SEG_BASE     24'h0C0000
`define IMD_SEG_TOP      24'h0DFFFF
`define IMD_HALF_MB      25'h0080000
`define IMD_ONE_MB       25'h0100000
`define IMD_IRQ_OFF      4'h0
`define IMD_TRIG_RESET   8'h00
`define IMD_ROUTE_RESET  8'h00
`define IMD_HOLE_RESET   8'h00
`define IMD_HALF_RESET   1'b1
`define IMD_RDATA_NONE   8'h00
`define IMD_TOP_MSB      15
`define IMD_TOP_LSB      12
`define IMD_FWD_EXT_BIT  11
`define IMD_FWD_VGA_BIT  10
`define IMD_FWD_BASE_BIT 9
`define IMD_FWD_LOW_BIT  8
`define IMD_MB_PAD       20'h00000
`define IMD_MB_MSB       23
`define IMD_MB_LSB       20
`define IMD_BLK_MSB      19
`define IMD_BLK_LSB      17
`define IMD_SEG_MSB      16
`define IMD_SEG_LSB      14
`define IMD_HOLE_LSB     16
`define IMD_LOW_MB       4'h0
`define IMD_BLK_BASE     3'h4
`define IMD_BLK_VGA      3'h5
`define IMD_BLK_SEG      3'h6
`define IMD_BLK_EXT      3'h7
`define IMD_TRIG_MSB     3
`define IMD_TRIG_PAD     4'h0
`define IMD_HALF_BIT     0
`define IMD_BOARD_INPUTS 2
`define IMD_ROUTE_W      4
`define IMD_IRQ_W        16
`define IMD_IRQ_ONE      16'h0001
`define IMD_IRQ_NONE     16'h0000
`endif

/* File: imd_isa_master.sv */
// Purpose: Behavioural ISA DMA or bus master issuing memory cycles.
// Assumes: The bench holds go_in high for each cycle to present.
// Notes:   Idle address is inverted each cycle, so a stale value returns on every second idle cycle.
`timescale 1ns/10ps
`default_nettype none
module imd_isa_master (
    input  wire logic        clk_in,
    input  wire logic        go_in,
    input  wire logic [23:0] addr_in,
    output var  logic        req_out = 1'b0,
    output var  logic [23:0] addr_out = 24'h000000
);
    // Change just after the edge so the block samples a settled cycle.
    always @(posedge clk_in) begin
        #1;
        req_out = go_in;
        addr_out = go_in ? addr_in : ~addr_out;
    end
endmodule
`default_nettype wire

/* File: imd_props.sv */
// Purpose: Port checker for the ISA decode and steering block.
// Assumes: Synchronous active high reset.
// Notes:   Attached to the block by implicit named ports.
`timescale 1ns/10ps
`default_nettype none
module imd_props (
    input wire logic        CLOCK_IN,
    input wire logic        SYS_RST_IN,
    input wire logic        CFG_WR_IN,
    input wire logic [7:0]  CFG_ADDR_IN,
    input wire logic [7:0]  CFG_WDATA_IN,
    input wire logic [7:0]  CFG_RDATA_OUT,
    input wire logic        ISA_REQ_IN,
    input wire logic        PCI_FWD_OUT,
    input wire logic        ISA_LOCAL_OUT,
    input wire logic [3:0]  PCI_INT_LINES_IN,
    input wire logic [3:0]  PCI_INT_COND_OUT,
    input wire logic [3:0]  PCI_INT_EDGE_OUT,
    input wire logic [15:0] ISA_IRQ_OUT
);
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // A request gets exactly one path next cycle, and idle gets none.
    chk_one_path: assert property (
        ISA_REQ_IN |=> PCI_FWD_OUT ^ ISA_LOCAL_OUT) else $error("one path");
    chk_idle_quiet: assert property (
        !ISA_REQ_IN |=> !PCI_FWD_OUT && !ISA_LOCAL_OUT) else $error("idle");
    // Read data follows the previous cycle's address; skip the reset cycle.
    chk_fixed_byte: assert property (
        !$past(SYS_RST_IN) && $past(CFG_ADDR_IN) == 8'h56
        |-> CFG_RDATA_OUT == 8'h04) else $error("fixed byte");
    chk_trig_upper: assert property (
        !$past(SYS_RST_IN) && $past(CFG_ADDR_IN) == 8'h54
        |-> CFG_RDATA_OUT[7:4] == 4'h0) else $error("upper bits");
    chk_cond_level: assert property (
        ($stable(PCI_INT_LINES_IN) && $stable(PCI_INT_EDGE_OUT))[*6]
        |-> PCI_INT_COND_OUT == (PCI_INT_LINES_IN ^ PCI_INT_EDGE_OUT))
        else $error("line polarity");
    chk_irq_none: assert property (
        ISA_IRQ_OUT[0] == 1'b0) else $error("code zero drove a line");
    chk_route_back: assert property (
        CFG_WR_IN && CFG_ADDR_IN == 8'h55 ##1 CFG_ADDR_IN == 8'h55
        |=> CFG_RDATA_OUT == $past(CFG_WDATA_IN, 2)) else $error("routing");
    chk_trig_back: assert property (
        CFG_WR_IN && CFG_ADDR_IN == 8'h54 ##1 CFG_ADDR_IN == 8'h54
        |=> CFG_RDATA_OUT == {4'h0, $past(CFG_WDATA_IN[3:0], 2)})
        else $error("trigger select");
    cover property (ISA_REQ_IN ##1 PCI_FWD_OUT);
    cover property (ISA_REQ_IN ##1 ISA_LOCAL_OUT);
    cover property (ISA_IRQ_OUT != 16'h0000);
endmodule
bind imd_decode imd_props u_props (.*);
`default_nettype wire

/* File: isa_master_decode_irq_steer_bench.sv */
// Purpose: Self-checking bench for the ISA decode and steering block.
// Assumes: Bench inputs change on the falling clock edge; the master moves the ISA cycle just after the rising one.
// Notes:   All waits are fixed counts taken from the stated latencies.
`timescale 1ns/10ps
`default_nettype none
module isa_master_decode_irq_steer_bench;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, go = 1'b0, b0 = 1'b0, b1 = 1'b0;
    logic [7:0] ad = 8'h00, wd = 8'h00, rd;
    logic [23:0] ga = 24'h000000, ia;
    logic req, fwd, loc;
    logic [3:0] ln = 4'h0, cnd, edg;
    logic [15:0] irq;
    int n_mismatch = 0, check_count = 0;
    always #10 clk = ~clk;
    imd_isa_master u_mst (.clk_in(clk), .go_in(go), .addr_in(ga),
        .req_out(req), .addr_out(ia));
    imd_decode uut (.CLOCK_IN(clk), .SYS_RST_IN(rst), .CFG_WR_IN(wr),
        .CFG_ADDR_IN(ad), .CFG_WDATA_IN(wd), .CFG_RDATA_OUT(rd),
        .ISA_REQ_IN(req), .ISA_ADDR_IN(ia), .PCI_FWD_OUT(fwd),
        .ISA_LOCAL_OUT(loc), .PCI_INT_LINES_IN(ln), .PCI_INT_COND_OUT(cnd),
        .PCI_INT_EDGE_OUT(edg), .BOARD_INT_INPUT_ZERO_IN(b0),
        .BOARD_INT_INPUT_ONE_IN(b1), .ISA_IRQ_OUT(irq));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic wrc(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) {wr, ad, wd} = {1'b1, a, d};
        @(negedge clk) wr = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk) ad = a;
        repeat (2) @(negedge clk);
        chk(rd, e);
    endtask
    // One memory cycle through the master; the answer lands one edge later.
    task automatic acc(input logic [23:0] a, input logic f);
        @(negedge clk) {go, ga} = {1'b1, a};
        @(negedge clk) go = 1'b0;
        @(negedge clk) chk({fwd, loc}, {f, ~f});
    endtask
    task automatic t_defaults();
        rdc(8'h4E, 8'h00);
        rdc(8'h4F, 8'h03);
        rdc(8'h48, 8'h01);
        rdc(8'h54, 8'h00);
        rdc(8'h55, 8'h00);
        rdc(8'h56, 8'h04);
    endtask
    task automatic t_ranges();
        acc(24'h000000, 1'b1);
        acc(24'h080000, 1'b1);
        acc(24'h0A0000, 1'b0);
        acc(24'h0E0000, 1'b0);
        acc(24'h0C0000, 1'b0);
        acc(24'h17FFFF, 1'b1);
        acc(24'h180000, 1'b0);
        wrc(8'h4F, 8'h0C);
        acc(24'h0EFFFF, 1'b1);
        acc(24'h0BFFFF, 1'b1);
        acc(24'h07FFFF, 1'b0);
        wrc(8'h4E, 8'h80);
        acc(24'h0DC000, 1'b1);
        acc(24'h0DBFFF, 1'b0);
    endtask
    task automatic t_limit_hole();
        wrc(8'h48, 8'h00);
        acc(24'h100000, 1'b0);
        wrc(8'h4F, 8'hF3);
        acc(24'hFFFFFF, 1'b1);
        wrc(8'h4C, 8'h10);
        wrc(8'h4D, 8'h12);
        acc(24'h11FFFF, 1'b0);
        acc(24'h120000, 1'b1);
        wrc(8'h4C, 8'h12);
        acc(24'h100000, 1'b1);
    endtask
    task automatic t_irq();
        wrc(8'h54, 8'hFA);
        rdc(8'h54, 8'h0A);
        @(negedge clk) {ln, b0, b1} = {4'hC, 2'b11};
        repeat (8) @(negedge clk);
        chk(edg, 4'hA);
        chk(cnd, 4'h6);
        chk(irq, 16'h0000);
        wrc(8'h55, 8'h31);
        rdc(8'h55, 8'h31);
        wrc(8'h56, 8'hFF);
        rdc(8'h56, 8'h04);
        chk(irq, 16'h000A);
        wrc(8'h55, 8'h30);
        repeat (3) @(negedge clk);
        chk(irq, 16'h0008);
    endtask
    // Mid-run reset must restore every default read back here while the pins stay busy; the hole bytes are not read.
    task automatic t_reset();
        @(negedge clk) rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        t_defaults();
        acc(24'h17FFFF, 1'b1);
        acc(24'h180000, 1'b0);
        chk(irq, 16'h0000);
        chk(edg, 4'h0);
        chk(cnd, 4'hC);
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        t_defaults();
        t_ranges();
        t_limit_hole();
        t_irq();
        t_reset();
        results();
    end
    // A hang counts as a mismatch.
    initial begin
        #100000;
        n_mismatch++;
        results();
    end
endmodule
`default_nettype wire
